//--- pkg/jfr_pkg.sv
// Purpose: Shared constants, TAP states and the TAP next-state function for the flash lockout recovery pair.
// Assumes: One 200 MHz clock on both ends; the JTAG pins are sampled as synchronous inputs.
// Notes: Instruction codes and flash word layout are local choices.
package jfr_pkg;
   localparam int IR_LEN = 4;
   localparam logic [3:0] IR_RECOVERY = 4'h8;
   localparam logic [3:0] IR_BYPASS = 4'hf;
   localparam logic [3:0] IR_CAPTURE = 4'h1;
   localparam int DIV_LEN = 7;
   localparam int PRESC_BIT = 6;
   localparam int RATIO_W = 6;
   localparam int FLASH_IN_DIV = 2;
   localparam int PRESC_DIV = 8;
   localparam int WORD_W = 16;
   localparam logic [15:0] ERASED_WORD = 16'hffff;
   localparam int CFG_FROM_TOP = 1;
   localparam int KEY_FROM_TOP = 2;
   localparam int SEC_LSB = 0;
   localparam logic [1:0] SECURE_CODE = 2'h2;
   localparam int KEY_ENABLE_BIT = 15;
   localparam int ERASE_SETTLE_TICKS = 4;
   localparam int CLK_PERIOD_PS = 5000;
   localparam int TCK_PERIOD_NS = 100;
   // Least half period, rounded up to whole clock cycles
   localparam int TCK_HALF_CYC = (TCK_PERIOD_NS * 1000 + 2 * CLK_PERIOD_PS - 1) / (2 * CLK_PERIOD_PS);
   localparam int PRE_RESET_STEPS = 5;
   localparam int RST_TCK = 4;

   typedef enum logic [3:0] {
      TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR, TAP_PAUSE_DR,
      TAP_EXIT2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SHIFT_IR, TAP_EXIT1_IR, TAP_PAUSE_IR,
      TAP_EXIT2_IR, TAP_UPD_IR
   } jfr_tap_t;

   typedef enum logic [2:0] {
      HST_IDLE, HST_SEQ, HST_HOLD, HST_RESET, HST_DONE
   } jfr_host_t;

   function automatic jfr_tap_t jfr_tap_next(input jfr_tap_t st, input logic tms);
      jfr_tap_t nx;
      nx = st;
      unique case (st)
         TAP_RESET: nx = tms ? TAP_RESET : TAP_IDLE;
         TAP_IDLE: nx = tms ? TAP_SEL_DR : TAP_IDLE;
         TAP_SEL_DR: nx = tms ? TAP_SEL_IR : TAP_CAP_DR;
         TAP_CAP_DR: nx = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
         TAP_SHIFT_DR: nx = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
         TAP_EXIT1_DR: nx = tms ? TAP_UPD_DR : TAP_PAUSE_DR;
         TAP_PAUSE_DR: nx = tms ? TAP_EXIT2_DR : TAP_PAUSE_DR;
         TAP_EXIT2_DR: nx = tms ? TAP_UPD_DR : TAP_SHIFT_DR;
         TAP_UPD_DR: nx = tms ? TAP_SEL_DR : TAP_IDLE;
         TAP_SEL_IR: nx = tms ? TAP_RESET : TAP_CAP_IR;
         TAP_CAP_IR: nx = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
         TAP_SHIFT_IR: nx = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
         TAP_EXIT1_IR: nx = tms ? TAP_UPD_IR : TAP_PAUSE_IR;
         TAP_PAUSE_IR: nx = tms ? TAP_EXIT2_IR : TAP_PAUSE_IR;
         TAP_EXIT2_IR: nx = tms ? TAP_UPD_IR : TAP_SHIFT_IR;
         TAP_UPD_IR: nx = tms ? TAP_SEL_DR : TAP_IDLE;
      endcase
      return nx;
   endfunction
endpackage

//--- pkg/jfr_jtag_if.sv
// Purpose: JTAG pins and external chip reset between the test host and the device.
// Assumes: All signals are plain levels sampled on the shared clock.
// Notes: No two-way pins; tdo is driven by the device at all times.
`timescale 1ns/1ps
interface jfr_jtag_if;
   logic tck;
   logic tms;
   logic tdi;
   logic tdo;
   logic trst_n;
   logic chip_rst_n;
   modport dev (input tck, input tms, input tdi, input trst_n, input chip_rst_n, output tdo);
   modport host (output tck, output tms, output tdi, output trst_n, output chip_rst_n, input tdo);
endinterface

//--- design/jfr_recovery_dev.sv
// Purpose: Device end: TAP with lockout recovery register, flash array, erase timing and security.
// Assumes: tck, tms, tdi, trst_n and chip_rst_n are synchronous to clock.
// Notes: The flash array is modelled as registers; rst_n stands for power-up only.
`timescale 1ns/1ps
// Summary of operation
// R01: Recovery erases whole flash, clearing security.
// R02: Recovery instruction selects 7-bit divider register.
// R03: Host loads divider before erase starts.
// R04: JTAG divider replaces flash timing divider.
// R05: Bit 6 prescales by eight; 5:0 ratio.
// R06: Host picks timing clock 150-200 kHz.
// R07: Prescale set above 12.8 MHz input.
// R08: Clock halved, optional /8, then /(ratio+1).
// R09: Instruction first, then divider data shift.
// R10: Entering Run-Test/Idle starts the erase.
// R11: Host holds Run-Test/Idle until erase done.
// R12: Host then asserts TRST and chip reset.
// R13: Backdoor key works only when enabled.
// R14: Program key, then code, security last.
// R15: Secured device blocks debug memory reads.
module jfr_recovery_dev
   import jfr_pkg::*;
#(
   parameter int DEPTH = 16
) (
   input wire logic clock,
   input wire logic rst_n,
   jfr_jtag_if.dev jtag,
   input wire logic [DIV_LEN-1:0] flash_timing_divider_reg,
   input wire logic prog_we,
   input wire logic [$clog2(DEPTH)-1:0] prog_addr,
   input wire logic [WORD_W-1:0] prog_data,
   input wire logic key_valid,
   input wire logic [WORD_W-1:0] key_value,
   input wire logic [$clog2(DEPTH)-1:0] dbg_rd_addr,
   output logic [WORD_W-1:0] dbg_rd_data,
   output logic secure,
   output logic debug_enable,
   output logic erase_busy,
   output logic erase_done,
   output logic timing_tick
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW-1:0] CFG_ADDR = AW'(DEPTH - CFG_FROM_TOP);
   localparam logic [AW-1:0] KEY_ADDR = AW'(DEPTH - KEY_FROM_TOP);
   localparam logic [AW-1:0] LAST_ADDR = AW'(DEPTH - 1);
   localparam logic [2:0] SETTLE_LAST = 3'(ERASE_SETTLE_TICKS - 1);

   typedef struct packed {
      logic tck_q;
      jfr_tap_t tap;
      logic [IR_LEN-1:0] ir_sh;
      logic [IR_LEN-1:0] ir;
      logic [DIV_LEN-1:0] dr_sh;
      logic bypass;
      logic [DIV_LEN-1:0] jtag_erase_clock_divider;
      logic div_loaded;
      logic tdo;
      logic erasing;
      logic walking;
      logic [AW-1:0] addr;
      logic [2:0] settle;
      logic done;
      logic [9:0] tcnt;
      logic tick;
      logic unlocked;
      logic secure;
      logic [WORD_W-1:0] rd_data;
      logic [DEPTH-1:0][WORD_W-1:0] mem;
   } jfr_dev_state_t;

   jfr_dev_state_t state_r;
   jfr_dev_state_t state_nxt;

   logic rise;
   logic fall;
   logic [DIV_LEN-1:0] div_sel;
   logic [10:0] ratio;
   logic [10:0] lim;
   logic tick_now;
   jfr_tap_t tap_nx;

   always_comb begin
      state_nxt = state_r;
      rise = jtag.tck & ~state_r.tck_q;
      fall = ~jtag.tck & state_r.tck_q;
      state_nxt.tck_q = jtag.tck;

      // Recovery divider overrides the normal one while erasing
      div_sel = state_r.erasing ? state_r.jtag_erase_clock_divider : flash_timing_divider_reg; // see R04
      ratio = 11'(div_sel[RATIO_W-1:0]) + 11'h001; // see R05
      lim = div_sel[PRESC_BIT] ? 11'(ratio * (FLASH_IN_DIV * PRESC_DIV)) : 11'(ratio * FLASH_IN_DIV); // see R08
      // Compare with >= so a divider change never strands the counter
      tick_now = ({1'b0, state_r.tcnt} >= lim - 11'h001);
      state_nxt.tcnt = tick_now ? 10'h000 : state_r.tcnt + 10'h001;
      state_nxt.tick = tick_now;

      tap_nx = jfr_tap_next(state_r.tap, jtag.tms);
      if (!jtag.trst_n) begin
         state_nxt.tap = TAP_RESET;
         state_nxt.ir = IR_BYPASS;
      end else if (rise) begin
         unique case (state_r.tap)
            TAP_RESET: state_nxt.ir = IR_BYPASS;
            TAP_CAP_IR: state_nxt.ir_sh = IR_CAPTURE;
            TAP_SHIFT_IR: state_nxt.ir_sh = {jtag.tdi, state_r.ir_sh[IR_LEN-1:1]};
            TAP_UPD_IR: state_nxt.ir = state_r.ir_sh;
            TAP_CAP_DR: begin
               state_nxt.dr_sh = state_r.jtag_erase_clock_divider;
               state_nxt.bypass = 1'b0;
            end
            TAP_SHIFT_DR: begin
               if (state_r.ir == IR_RECOVERY) begin
                  state_nxt.dr_sh = {jtag.tdi, state_r.dr_sh[DIV_LEN-1:1]}; // see R02
               end else begin
                  state_nxt.bypass = jtag.tdi;
               end
            end
            TAP_UPD_DR: begin
               if (state_r.ir == IR_RECOVERY) begin
                  state_nxt.jtag_erase_clock_divider = state_r.dr_sh; // see R02
                  state_nxt.div_loaded = 1'b1; // see R03
               end
            end
            default: ;
         endcase
         state_nxt.tap = tap_nx;
         // Erase is armed only by a divider loaded under the recovery instruction
         // Update-DR hands over on the same rise that enters idle, so look at the next value
         if (tap_nx == TAP_IDLE && state_r.tap != TAP_IDLE && state_r.ir == IR_RECOVERY &&
             state_nxt.div_loaded && !state_r.erasing) begin
            state_nxt.erasing = 1'b1; // see R10
            state_nxt.walking = 1'b1;
            state_nxt.addr = '0;
            state_nxt.settle = 3'h0;
            state_nxt.done = 1'b0;
         end
      end

      if (fall) begin
         if (state_r.tap == TAP_SHIFT_IR) begin
            state_nxt.tdo = state_r.ir_sh[0];
         end else if (state_r.tap == TAP_SHIFT_DR) begin
            state_nxt.tdo = (state_r.ir == IR_RECOVERY) ? state_r.dr_sh[0] : state_r.bypass;
         end
      end

      // One word per timing tick, then a short settle before done
      if (state_r.erasing && state_r.tick) begin
         if (state_r.walking) begin
            state_nxt.mem[state_r.addr] = ERASED_WORD; // see R01
            state_nxt.addr = state_r.addr + AW'(1);
            if (state_r.addr == LAST_ADDR) begin
               state_nxt.walking = 1'b0;
            end
         end else if (state_r.settle == SETTLE_LAST) begin
            state_nxt.erasing = 1'b0;
            state_nxt.done = 1'b1;
            state_nxt.unlocked = 1'b0;
         end else begin
            state_nxt.settle = state_r.settle + 3'h1;
         end
      end else if (prog_we && !state_r.erasing) begin
         state_nxt.mem[prog_addr] = prog_data;
      end

      if (key_valid && state_r.mem[CFG_ADDR][KEY_ENABLE_BIT] && key_value == state_r.mem[KEY_ADDR]) begin
         state_nxt.unlocked = 1'b1; // see R13
      end

      // Erased security field never matches the secure code
      state_nxt.secure = (state_r.mem[CFG_ADDR][SEC_LSB+:2] == SECURE_CODE) && !state_r.unlocked; // see R01
      state_nxt.rd_data = state_r.secure ? '0 : state_r.mem[dbg_rd_addr]; // see R15

      if (!jtag.chip_rst_n) begin
         state_nxt.unlocked = 1'b0;
         state_nxt.done = 1'b0;
         state_nxt.div_loaded = 1'b0;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= '0;
      end else begin
         state_r <= state_nxt;
      end
   end

   assign jtag.tdo = state_r.tdo;
   assign dbg_rd_data = state_r.rd_data;
   assign secure = state_r.secure;
   assign debug_enable = ~state_r.secure; // see R15
   assign erase_busy = state_r.erasing;
   assign erase_done = state_r.done;
   assign timing_tick = state_r.tick;
endmodule

//--- design/jfr_recovery_host.sv
// Purpose: Host end: drives the lockout recovery sequence over JTAG, then resets TAP and chip.
// Assumes: TCK is made here from clock by a divider; the device sees it as a plain input.
// Notes: Erase completion is not observable on the pins, so the hold time is a parameter.
`timescale 1ns/1ps
module jfr_recovery_host
   import jfr_pkg::*;
#(
   parameter int HOLD_TCK = 2048
) (
   input wire logic clock,
   input wire logic rst_n,
   jfr_jtag_if.host jtag,
   input wire logic start,
   input wire logic [DIV_LEN-1:0] divider,
   output logic busy,
   output logic done
);
   localparam int SEQ_IR0 = PRE_RESET_STEPS + 5;
   localparam int SEQ_DR0 = SEQ_IR0 + IR_LEN + 4;
   localparam int SEQ_LEN = SEQ_DR0 + DIV_LEN + 2;

   typedef struct packed {
      jfr_host_t st;
      logic [7:0] hcnt;
      logic tck;
      logic tms;
      logic tdi;
      logic [5:0] step;
      logic [15:0] cnt;
      logic trst_act;
      logic chip_rst_act;
      logic [DIV_LEN-1:0] div;
   } jfr_host_state_t;

   jfr_host_state_t state_r;
   jfr_host_state_t state_nxt;
   logic tck_en;

   // Returns {tms, tdi} for one step: TAP reset, IR load, DR load, enter idle
   function automatic logic [1:0] seq_bits(input logic [5:0] step, input logic [DIV_LEN-1:0] dv);
      int i;
      logic [1:0] b;
      i = int'(step);
      b = 2'h0;
      if (i < PRE_RESET_STEPS) begin
         b = 2'h2;
      end else if (i < SEQ_IR0) begin
         b = (i == PRE_RESET_STEPS + 1 || i == PRE_RESET_STEPS + 2) ? 2'h2 : 2'h0;
      end else if (i < SEQ_IR0 + IR_LEN) begin
         b = {i == SEQ_IR0 + IR_LEN - 1, IR_RECOVERY[i-SEQ_IR0]}; // see R09
      end else if (i < SEQ_DR0) begin
         b = (i < SEQ_IR0 + IR_LEN + 2) ? 2'h2 : 2'h0;
      end else if (i < SEQ_DR0 + DIV_LEN) begin
         b = {i == SEQ_DR0 + DIV_LEN - 1, dv[i-SEQ_DR0]}; // see R03
      end else begin
         b = (i == SEQ_DR0 + DIV_LEN) ? 2'h2 : 2'h0; // see R10
      end
      return b;
   endfunction

   always_comb begin
      state_nxt = state_r;
      tck_en = 1'b0;
      if (state_r.st == HST_SEQ || state_r.st == HST_HOLD || state_r.st == HST_RESET) begin
         tck_en = (state_r.hcnt == 8'(TCK_HALF_CYC - 1));
         state_nxt.hcnt = tck_en ? 8'h00 : state_r.hcnt + 8'h01;
      end
      unique case (state_r.st)
         HST_IDLE, HST_DONE: begin
            if (start) begin
               // Divider chosen by the user for 150-200 kHz, prescale above 12.8 MHz
               state_nxt.div = divider; // see R06
               state_nxt.st = HST_SEQ;
               state_nxt.step = 6'h00;
               state_nxt.hcnt = 8'h00;
               {state_nxt.tms, state_nxt.tdi} = seq_bits(6'h00, divider);
            end
         end
         HST_SEQ: begin
            if (tck_en && state_r.tck) begin
               if (state_r.step == 6'(SEQ_LEN - 1)) begin
                  state_nxt.st = HST_HOLD;
                  state_nxt.tms = 1'b0; // see R11
                  state_nxt.cnt = 16'h0000;
               end else begin
                  state_nxt.step = state_r.step + 6'h01;
                  {state_nxt.tms, state_nxt.tdi} = seq_bits(state_r.step + 6'h01, state_r.div);
               end
            end
         end
         HST_HOLD: begin
            if (tck_en && state_r.tck) begin
               state_nxt.cnt = state_r.cnt + 16'h0001;
               if (state_r.cnt == 16'(HOLD_TCK - 1)) begin
                  state_nxt.st = HST_RESET;
                  state_nxt.trst_act = 1'b1; // see R12
                  state_nxt.chip_rst_act = 1'b1;
                  state_nxt.cnt = 16'h0000;
               end
            end
         end
         HST_RESET: begin
            if (tck_en && state_r.tck) begin
               state_nxt.cnt = state_r.cnt + 16'h0001;
               if (state_r.cnt == 16'(RST_TCK - 1)) begin
                  state_nxt.st = HST_DONE;
                  state_nxt.trst_act = 1'b0;
                  state_nxt.chip_rst_act = 1'b0;
               end
            end
         end
      endcase
      if (tck_en) begin
         state_nxt.tck = ~state_r.tck;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= '0;
      end else begin
         state_r <= state_nxt;
      end
   end

   assign jtag.tck = state_r.tck;
   assign jtag.tms = state_r.tms;
   assign jtag.tdi = state_r.tdi;
   assign jtag.trst_n = ~state_r.trst_act;
   assign jtag.chip_rst_n = ~state_r.chip_rst_act;
   assign busy = (state_r.st != HST_IDLE) && (state_r.st != HST_DONE);
   assign done = (state_r.st == HST_DONE);
endmodule

//--- test/jfr_recovery_chk.sv
// Purpose: Assertions on the JTAG wires and device status of the recovery pair.
// Assumes: All inputs are sampled on clock; the TAP is tracked from detected tck rises.
// Notes: IR contents are not tracked, only the order of the updates.
`timescale 1ns/1ps
module jfr_recovery_chk
   import jfr_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic tck,
   input wire logic tms,
   input wire logic trst_n,
   input wire logic chip_rst_n,
   input wire logic tdo,
   input wire logic secure,
   input wire logic debug_enable,
   input wire logic erase_busy,
   input wire logic erase_done,
   input wire logic timing_tick,
   input wire logic [WORD_W-1:0] dbg_rd_data
);
   jfr_tap_t tap_r;
   logic tck_r;
   logic ir_r;
   logic dr_r;
   logic in_shift;
   assign in_shift = (tap_r == TAP_SHIFT_IR) || (tap_r == TAP_SHIFT_DR);
   // Same sampling as the device, so the tracked TAP never runs ahead of it
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         tap_r <= TAP_RESET;
         tck_r <= 1'h0;
         ir_r <= 1'h0;
         dr_r <= 1'h0;
      end else begin
         tck_r <= tck;
         if (!trst_n) begin
            tap_r <= TAP_RESET;
            ir_r <= 1'h0;
            dr_r <= 1'h0;
         end else if (tck && !tck_r) begin
            tap_r <= jfr_tap_next(tap_r, tms);
            if (tap_r == TAP_UPD_IR) ir_r <= 1'h1;
            if (tap_r == TAP_UPD_DR) dr_r <= 1'h1;
         end
      end
   end
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);
   property p_dbg_off;
      secure |-> !debug_enable;
   endproperty
   a_dbg_off: assert property (p_dbg_off)
      else $error("debug port open while secure");
   property p_dbg_zero;
      secure && $past(secure) |-> dbg_rd_data == 16'h0;
   endproperty
   a_dbg_zero: assert property (p_dbg_zero)
      else $error("memory visible while secure");
   property p_tick_gap;
      timing_tick |=> !timing_tick;
   endproperty
   a_tick_gap: assert property (p_tick_gap)
      else $error("timing tick faster than half clock");
   property p_erase_start;
      $rose(erase_busy) |-> tap_r == TAP_IDLE;
   endproperty
   a_erase_start: assert property (p_erase_start)
      else $error("erase started outside idle");
   property p_div_first;
      $rose(erase_busy) |-> dr_r;
   endproperty
   a_div_first: assert property (p_div_first)
      else $error("erase started before divider update");
   property p_ir_first;
      tap_r == TAP_SHIFT_DR |-> ir_r;
   endproperty
   a_ir_first: assert property (p_ir_first)
      else $error("data shifted before instruction");
   property p_hold_idle;
      erase_busy |-> tap_r == TAP_IDLE && trst_n;
   endproperty
   a_hold_idle: assert property (p_hold_idle)
      else $error("host left idle during erase");
   property p_both_rst;
      $fell(trst_n) |-> (!trst_n && !chip_rst_n) [*8];
   endproperty
   a_both_rst: assert property (p_both_rst)
      else $error("tap and chip reset not held together");
   property p_erase_end;
      $fell(erase_busy) |-> erase_done ##1 !secure;
   endproperty
   a_erase_end: assert property (p_erase_end)
      else $error("erase end left device secure");
   property p_tdo_shift;
      $changed(tdo) |-> $past(in_shift);
   endproperty
   a_tdo_shift: assert property (p_tdo_shift)
      else $error("tdo moved outside a shift state");
   c_erase: cover property ($rose(erase_busy));
   c_trst: cover property ($fell(trst_n));
   c_unlock: cover property ($fell(secure));
endmodule

//--- test/jfr_recovery_bench.sv
// Purpose: Self-checking bench joining host and device ends of the recovery pair.
// Assumes: Device flash depth 16; host hold long enough for the slowest divider.
// Notes: Tick period is measured only while erasing, when the JTAG divider rules.
`timescale 1ns/1ps
module jfr_recovery_bench;
   import jfr_pkg::*;
   logic clock = 1'h0, rst_n = 1'h0, start = 1'h0, prog_we = 1'h0, key_valid = 1'h0;
   logic [6:0] divider = 7'h0, fdiv = 7'h0;
   logic [3:0] prog_addr = 4'h0, dbg_rd_addr = 4'h0;
   logic [15:0] prog_data = 16'h0, key_value = 16'h0, kv, dbg_rd_data;
   logic busy, done, secure, debug_enable, erase_busy, erase_done, timing_tick;
   logic saw_done = 1'h0;
   int miscompares = 0, compares = 0, seed, cyc = 0, last = 0, per = 0;
   jfr_jtag_if jtag();
   jfr_recovery_host #(.HOLD_TCK(1100)) jfr_recovery_host_i (.clock(clock), .rst_n(rst_n),
      .jtag(jtag), .start(start), .divider(divider), .busy(busy), .done(done));
   jfr_recovery_dev jfr_recovery_dev_i (.clock(clock), .rst_n(rst_n), .jtag(jtag),
      .flash_timing_divider_reg(fdiv), .prog_we(prog_we), .prog_addr(prog_addr),
      .prog_data(prog_data), .key_valid(key_valid), .key_value(key_value),
      .dbg_rd_addr(dbg_rd_addr), .dbg_rd_data(dbg_rd_data), .secure(secure),
      .debug_enable(debug_enable), .erase_busy(erase_busy), .erase_done(erase_done),
      .timing_tick(timing_tick));
   jfr_recovery_chk jfr_recovery_chk_i (.clock(clock), .rst_n(rst_n), .tck(jtag.tck),
      .tms(jtag.tms), .trst_n(jtag.trst_n), .chip_rst_n(jtag.chip_rst_n), .tdo(jtag.tdo), .secure(secure),
      .debug_enable(debug_enable), .erase_busy(erase_busy), .erase_done(erase_done),
      .timing_tick(timing_tick), .dbg_rd_data(dbg_rd_data));
   always #2.5 clock = ~clock;
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (erase_busy && timing_tick) begin
         per <= cyc - last;
         last <= cyc;
      end
      if (erase_done) saw_done <= 1'h1;
   end
   function automatic int exp_per(input logic [6:0] d);
      return (d[6] ? FLASH_IN_DIV * PRESC_DIV : FLASH_IN_DIV) * (int'(d[5:0]) + 1);
   endfunction
   task automatic chk_word(input logic [15:0] got, input logic [15:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask
   task automatic chk_flag(input logic got, input logic exp, input string what);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: %s got %b", $time, what, got);
      end
   endtask
   task automatic settle;
      repeat (3) @(posedge clock);
      @(negedge clock);
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clock);
      prog_we <= 1'h1;
      prog_addr <= a;
      prog_data <= d;
      @(posedge clock);
      prog_we <= 1'h0;
   endtask
   task automatic try_key(input logic [15:0] k);
      @(posedge clock);
      key_valid <= 1'h1;
      key_value <= k;
      @(posedge clock);
      key_valid <= 1'h0;
      settle();
   endtask
   task automatic rd(input logic [3:0] a, input logic [15:0] exp);
      @(posedge clock);
      dbg_rd_addr <= a;
      repeat (2) @(posedge clock);
      @(negedge clock);
      chk_word(dbg_rd_data, exp, "debug read");
   endtask
   task automatic recover(input logic [6:0] d);
      int n;
      @(posedge clock);
      divider <= d;
      fdiv <= ~d;
      start <= 1'h1;
      saw_done <= 1'h0;
      @(posedge clock);
      start <= 1'h0;
      @(negedge clock);
      chk_flag(busy, 1'h1, "host busy");
      n = 0;
      while (done !== 1'h1 && n < 40000) begin
         @(posedge clock);
         n++;
      end
      @(negedge clock);
      chk_flag(done, 1'h1, "sequence done");
      chk_flag(busy, 1'h0, "host idle after resets");
      chk_flag(saw_done, 1'h1, "erase done");
      chk_word(16'(per), 16'(exp_per(d)), "tick period");
      chk_flag(secure, 1'h0, "secure after erase");
      chk_flag(debug_enable, 1'h1, "debug after erase");
      for (int a = 0; a < 16; a++) rd(4'(a), ERASED_WORD);
   endtask
   task automatic print_verdict;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   initial begin
      seed = 32'h6894e142;
      repeat (3) @(posedge clock);
      rst_n <= 1'h1;
      kv = 16'($random(seed));
      wr(4'he, kv);
      wr(4'hf, 16'h0002);
      settle();
      chk_flag(secure, 1'h1, "secure after lock");
      chk_flag(debug_enable, 1'h0, "debug while locked");
      rd(4'he, 16'h0);
      try_key(kv);
      chk_flag(secure, 1'h1, "key with enable clear");
      recover(7'h00);
      $display("test lockout_recovery done");
      wr(4'he, kv);
      wr(4'h3, ~kv);
      wr(4'hf, 16'h8002);
      settle();
      chk_flag(secure, 1'h1, "secure with key enabled");
      try_key(kv ^ 16'h0001);
      chk_flag(secure, 1'h1, "wrong key");
      try_key(kv);
      chk_flag(secure, 1'h0, "right key");
      rd(4'h3, ~kv);
      $display("test backdoor_key done");
      // Flash input is 100 MHz, so prescale on; ratio 62 or 63 gives 195-198 kHz
      recover({1'b1, 5'h1f, 1'($random(seed))});
      $display("test random_divider done");
      print_verdict();
   end
   initial begin
      #400000;
      miscompares++;
      $display("unexpected at %0t: watchdog expired", $time);
      print_verdict();
   end
endmodule
